// ===== core/pbd_map.svh
// Register offsets, field positions, reset values and divider constants
`ifndef PBD_MAP_SVH
`define PBD_MAP_SVH

`define PBD_ADDR_W 4
`define PBD_REG_OUT_CTRL 4'h3
`define PBD_REG_RATIOS 4'h5
`define PBD_REG_PLL1_CFG_A 4'h6
`define PBD_REG_PLL1_CFG_B 4'h7
`define PBD_REG_PLL2_CFG_A 4'h8
`define PBD_REG_PLL2_CFG_B 4'h9
`define PBD_REG_PLL1_GAIN 4'hC
`define PBD_REG_PLL2_GAIN 4'hE
`define PBD_REG_STATUS 4'hF

`define PBD_HALF_LSB 8
`define PBD_BAND_LSB 24
`define PBD_CUR_LSB 16
`define PBD_FBRST_BIT 14
`define PBD_ORDER_LSB 29
`define PBD_GAIN_BIT 31
`define PBD_LOCK1_BIT 21
`define PBD_LOCK2_BIT 23
`define PBD_UNLOCK_EN_BIT 0
`define PBD_RATIO_W 8

`define PBD_REG_RST 32'h0000_0000
`define PBD_RATIOS_RST 32'h0404_0404
`define PBD_ORDER_INT 3'h0
`define PBD_DIV_MIN_CODE 8'h04
`define PBD_DIV_WRAP_BASE 9'h100
`define PBD_HALF_SHORT 9'h004
`define PBD_HALF_LONG 9'h005
`define PBD_CNT_ZERO 9'h000
`define PBD_CNT_ONE 9'h001

`endif

// ===== core/pbd_pkg.sv
// Types shared by the PLL band, divider and lock control block
package pbd_pkg;
  typedef logic [31:0] pbd_word_t;
  typedef logic [15:0][31:0] pbd_regs_t;
  typedef logic [8:0] pbd_count_t;

  typedef struct packed {
    pbd_regs_t regs;
    logic [1:0] lock_meta;
    logic [1:0] lock_sync;
    logic [1:0] int_mode;
    logic serial_out;
    pbd_word_t rdata;
    logic rvalid;
  } pbd_ctrl_state_t;

  typedef struct packed {
    pbd_count_t cnt;
    pbd_count_t period;
    logic long_half;
    logic clk_out;
  } pbd_div_state_t;
endpackage : pbd_pkg

// ===== core/pbd_out_div.sv
// One output divider: wrap-around ratio decode, half-step mode, boundary updates
`timescale 1ns/1ps
`include "pbd_map.svh"

module pbd_out_div (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Oscillator tick and settings
  input wire logic osc_tick_in,
  input wire logic [7:0] ratio_code_in,
  input wire logic half_mode_in,
  // Divided clock
  output logic div_clk_out
);
  import pbd_pkg::*;

  pbd_div_state_t state;
  pbd_div_state_t next_state;

  function automatic pbd_count_t decode_ratio(input logic [7:0] code);
    if (code < `PBD_DIV_MIN_CODE)
      decode_ratio = `PBD_DIV_WRAP_BASE + {1'b0, code};
    else
      decode_ratio = {1'b0, code};
  endfunction : decode_ratio

  always_comb
  begin
    next_state = state;
    if (osc_tick_in)
    begin
      if (state.cnt >= state.period - `PBD_CNT_ONE)
      begin
        // New ratio only at the period boundary, so no short pulse
        next_state.cnt = `PBD_CNT_ZERO;
        if (half_mode_in)
        begin
          // Alternate 4 and 5 ticks for an average of 4.5
          next_state.long_half = ~state.long_half;
          next_state.period = state.long_half ? `PBD_HALF_SHORT : `PBD_HALF_LONG;
        end
        else
          next_state.period = decode_ratio(ratio_code_in);
      end
      else
        next_state.cnt = state.cnt + `PBD_CNT_ONE;
    end
    next_state.clk_out = next_state.cnt < (next_state.period >> 1);
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state.cnt <= `PBD_CNT_ZERO;
      state.period <= `PBD_HALF_SHORT;
      state.long_half <= 1'b0;
      state.clk_out <= 1'b1;
    end
    else
      state <= next_state;
  end

  assign div_clk_out = state.clk_out;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  count_bound_a: assert property (state.cnt < state.period)
    else $error("divider count passed its period");

  ratio_load_a: assert property (
    (osc_tick_in && !half_mode_in && state.cnt == state.period - `PBD_CNT_ONE)
    |=> state.period == decode_ratio($past(ratio_code_in)))
    else $error("divider loaded a wrong period");

  half_step_a: assert property (
    (osc_tick_in && half_mode_in && state.cnt == state.period - `PBD_CNT_ONE)
    |=> (state.period == `PBD_HALF_SHORT || state.period == `PBD_HALF_LONG)
        && state.long_half != $past(state.long_half))
    else $error("half step mode did not alternate four and five");
endmodule : pbd_out_div

// ===== core/pbd_ctrl.sv
// Register file, lock detection, unlock pin and output dividers of the dual PLL
`timescale 1ns/1ps
`include "pbd_map.svh"

// Notes on behaviour
// - Each PLL picks one of 32 bands
// - Pump current from bits 20:16 of second register
// - Four ratio codes packed in one register
// - Codes 0-3 divide by 256-259, else code
// - Half-step bit forces divide by 4.5
// - Lock bits 21 and 23 in status register
// - Unlock enable makes pin AND of unlocks
// - Feedback divider word applies immediately
// - Order zero integer, one to four fractional
module pbd_ctrl (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire pbd_pkg::pbd_word_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output pbd_pkg::pbd_word_t reg_rdata_out,
  output logic reg_rvalid_out,
  // Analog side inputs
  input wire logic [1:0] pll_lock_in,
  input wire logic [1:0] osc_tick_in,
  input wire logic spi_data_in,
  // PLL settings
  output logic [1:0][4:0] osc_band_out,
  output logic [1:0] osc_gain_band_out,
  output logic [1:0][4:0] pump_current_code_out,
  output logic [1:0][2:0] modulator_order_out,
  output logic [1:0] integer_mode_out,
  output logic [1:0][31:0] fb_divider_word_out,
  output logic [1:0] fb_divider_reset_out,
  // Outputs
  output logic [3:0] output_clk_out,
  output logic serial_out_unlock_pin_out
);
  import pbd_pkg::*;

  pbd_ctrl_state_t state;
  pbd_ctrl_state_t next_state;
  logic unlock_mode;

  function automatic logic [3:0] cfg_a_addr(input int pll);
    cfg_a_addr = (pll == 0) ? `PBD_REG_PLL1_CFG_A : `PBD_REG_PLL2_CFG_A;
  endfunction : cfg_a_addr

  function automatic logic [3:0] cfg_b_addr(input int pll);
    cfg_b_addr = (pll == 0) ? `PBD_REG_PLL1_CFG_B : `PBD_REG_PLL2_CFG_B;
  endfunction : cfg_b_addr

  function automatic pbd_word_t read_word(input pbd_ctrl_state_t s, input logic [3:0] a);
    pbd_word_t w;
    w = s.regs[a];
    if (a == `PBD_REG_STATUS)
    begin
      w = `PBD_REG_RST;
      w[`PBD_LOCK1_BIT] = s.lock_sync[0];
      w[`PBD_LOCK2_BIT] = s.lock_sync[1];
    end
    read_word = w;
  endfunction : read_word

  assign unlock_mode = state.regs[cfg_a_addr(0)][`PBD_UNLOCK_EN_BIT]
    | state.regs[cfg_a_addr(1)][`PBD_UNLOCK_EN_BIT];

  always_comb
  begin
    next_state = state;
    next_state.lock_meta = pll_lock_in;
    next_state.lock_sync = state.lock_meta;
    // Reserved bits of 11-14 are stored as written and read back unchanged
    if (reg_wr_in && reg_addr_in != `PBD_REG_STATUS)
      next_state.regs[reg_addr_in] = reg_wdata_in;
    next_state.rvalid = reg_rd_in;
    next_state.rdata = reg_rd_in ? read_word(state, reg_addr_in) : `PBD_REG_RST;
    // Pin shows combined loss of lock while either PLL enables it
    if (unlock_mode)
      next_state.serial_out = ~state.lock_sync[0] & ~state.lock_sync[1];
    else
      next_state.serial_out = spi_data_in;
    for (int p = 0; p < 2; p++)
      next_state.int_mode[p] =
        state.regs[cfg_b_addr(p)][`PBD_ORDER_LSB +: 3] == `PBD_ORDER_INT;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int r = 0; r < 16; r++)
        state.regs[r] <= `PBD_REG_RST;
      state.regs[`PBD_REG_RATIOS] <= `PBD_RATIOS_RST;
      state.lock_meta <= 2'h0;
      state.lock_sync <= 2'h0;
      state.int_mode <= 2'h3;
      state.serial_out <= 1'b0;
      state.rdata <= `PBD_REG_RST;
      state.rvalid <= 1'b0;
    end
    else
      state <= next_state;
  end

  assign reg_rdata_out = state.rdata;
  assign reg_rvalid_out = state.rvalid;
  assign serial_out_unlock_pin_out = state.serial_out;
  assign integer_mode_out = state.int_mode;

  generate
    for (genvar p = 0; p < 2; p++)
    begin : g_pll
      localparam logic [3:0] AddrA = p == 0 ? `PBD_REG_PLL1_CFG_A : `PBD_REG_PLL2_CFG_A;
      localparam logic [3:0] AddrB = p == 0 ? `PBD_REG_PLL1_CFG_B : `PBD_REG_PLL2_CFG_B;
      localparam logic [3:0] AddrG = p == 0 ? `PBD_REG_PLL1_GAIN : `PBD_REG_PLL2_GAIN;
      assign osc_band_out[p] = state.regs[AddrB][`PBD_BAND_LSB +: 5];
      assign osc_gain_band_out[p] = state.regs[AddrG][`PBD_GAIN_BIT];
      assign pump_current_code_out[p] = state.regs[AddrB][`PBD_CUR_LSB +: 5];
      assign modulator_order_out[p] = state.regs[AddrB][`PBD_ORDER_LSB +: 3];
      // Word goes out with no staging so the running divider picks it up at once
      assign fb_divider_word_out[p] = state.regs[AddrA];
      assign fb_divider_reset_out[p] = state.regs[AddrB][`PBD_FBRST_BIT];
    end
    for (genvar o = 0; o < 4; o++)
    begin : g_out
      pbd_out_div pbd_out_div_i (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .osc_tick_in(osc_tick_in[o / 2]),
        .ratio_code_in(state.regs[`PBD_REG_RATIOS][o * `PBD_RATIO_W +: `PBD_RATIO_W]),
        .half_mode_in(state.regs[`PBD_REG_OUT_CTRL][`PBD_HALF_LSB + o]),
        .div_clk_out(output_clk_out[o])
      );
    end
  endgenerate

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence wr_to(logic [3:0] a);
    reg_wr_in && reg_addr_in == a;
  endsequence

  sequence both_unlocked_steady;
    (!pll_lock_in[0] && !pll_lock_in[1] && unlock_mode) [*4];
  endsequence

  sequence status_read;
    reg_rd_in && reg_addr_in == `PBD_REG_STATUS;
  endsequence

  band_select_a: assert property (wr_to(`PBD_REG_PLL1_CFG_B)
    |=> osc_band_out[0] == $past(reg_wdata_in[28:24]))
    else $error("band select did not follow the write");

  pump_current_a: assert property (wr_to(`PBD_REG_PLL2_CFG_B)
    |=> pump_current_code_out[1] == $past(reg_wdata_in[20:16]))
    else $error("pump current did not follow the write");

  ratio_readback_a: assert property (
    wr_to(`PBD_REG_RATIOS) ##1 (reg_rd_in && !reg_wr_in && reg_addr_in == `PBD_REG_RATIOS)
    |=> reg_rvalid_out && reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("ratio register read back wrong");

  lock_status_a: assert property (
    pll_lock_in[1] [*3] ##0 (reg_rd_in && reg_addr_in == `PBD_REG_STATUS)
    |=> reg_rdata_out[23] && reg_rvalid_out)
    else $error("lock bit not reported");

  unlock_pin_a: assert property (both_unlocked_steady |=> serial_out_unlock_pin_out)
    else $error("unlock pin low while both PLLs unlocked");

  fb_immediate_a: assert property (wr_to(`PBD_REG_PLL2_CFG_A)
    |=> fb_divider_word_out[1] == $past(reg_wdata_in))
    else $error("feedback divider word delayed");

  int_mode_a: assert property (
    wr_to(`PBD_REG_PLL1_CFG_B) ##1 !(reg_wr_in && reg_addr_in == `PBD_REG_PLL1_CFG_B)
    |=> integer_mode_out[0] == ($past(reg_wdata_in[31:29], 2) == `PBD_ORDER_INT))
    else $error("integer mode flag wrong");

  int_mode2_a: assert property (
    wr_to(`PBD_REG_PLL2_CFG_B) ##1 !(reg_wr_in && reg_addr_in == `PBD_REG_PLL2_CFG_B)
    |=> integer_mode_out[1] == ($past(reg_wdata_in[`PBD_ORDER_LSB +: 3], 2) == `PBD_ORDER_INT))
    else $error("second integer mode flag wrong");

  band_select2_a: assert property (wr_to(`PBD_REG_PLL2_CFG_B)
    |=> osc_band_out[1] == $past(reg_wdata_in[`PBD_BAND_LSB +: 5]))
    else $error("second band select did not follow the write");

  pump_current1_a: assert property (wr_to(`PBD_REG_PLL1_CFG_B)
    |=> pump_current_code_out[0] == $past(reg_wdata_in[`PBD_CUR_LSB +: 5]))
    else $error("first pump current did not follow the write");

  order_field_a: assert property (wr_to(`PBD_REG_PLL1_CFG_B)
    |=> modulator_order_out[0] == $past(reg_wdata_in[`PBD_ORDER_LSB +: 3]))
    else $error("modulator order did not follow the write");

  fb_immediate1_a: assert property (wr_to(`PBD_REG_PLL1_CFG_A)
    |=> fb_divider_word_out[0] == $past(reg_wdata_in))
    else $error("first feedback divider word delayed");

  lock1_status_a: assert property (
    pll_lock_in[0] [*3] ##0 status_read
    |=> reg_rdata_out[`PBD_LOCK1_BIT] && reg_rvalid_out)
    else $error("first lock bit not reported");

  unlock_status_a: assert property (
    (!pll_lock_in[0]) [*3] ##0 status_read
    |=> !reg_rdata_out[`PBD_LOCK1_BIT])
    else $error("lock bit set while unlocked");

  // Only the two lock bits may ever be set in a status answer
  status_spare_a: assert property (status_read
    |=> (reg_rdata_out & ~(32'h0000_0001 << `PBD_LOCK1_BIT)
      & ~(32'h0000_0001 << `PBD_LOCK2_BIT)) == `PBD_REG_RST)
    else $error("status spare bits not zero");

  rdata_idle_a: assert property (!reg_rd_in
    |=> !reg_rvalid_out && reg_rdata_out == `PBD_REG_RST)
    else $error("read data not cleared without a read");

  serial_data_a: assert property (!unlock_mode
    |=> serial_out_unlock_pin_out == $past(spi_data_in))
    else $error("pin did not carry serial data");

  unlock_pin_low_a: assert property (
    (pll_lock_in[0] && unlock_mode) [*3]
    |=> !serial_out_unlock_pin_out)
    else $error("unlock pin high while first PLL locked");
endmodule : pbd_ctrl

// ===== verification/pbd_ctrl_tb.sv
// Self-checking bench for the PLL band, divider and lock control block
`timescale 1ns/1ps
`include "pbd_map.svh"

module pbd_ctrl_tb;
  import pbd_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  pbd_word_t reg_wdata_in = 32'h0000_0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  pbd_word_t reg_rdata_out;
  logic reg_rvalid_out;
  logic [1:0] pll_lock_in = 2'h3;
  logic [1:0] osc_tick_in = 2'h3;
  logic spi_data_in = 1'b0;
  logic [1:0][4:0] osc_band_out;
  logic [1:0] osc_gain_band_out;
  logic [1:0][4:0] pump_current_code_out;
  logic [1:0][2:0] modulator_order_out;
  logic [1:0] integer_mode_out;
  logic [1:0][31:0] fb_divider_word_out;
  logic [1:0] fb_divider_reset_out;
  logic [3:0] output_clk_out;
  logic serial_out_unlock_pin_out;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int hi;
  int p1;
  int p2;
  int exp_p[4] = '{5, 0, 259, 255};

  pbd_ctrl pbd_ctrl_i (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .pll_lock_in(pll_lock_in), .osc_tick_in(osc_tick_in), .spi_data_in(spi_data_in),
    .osc_band_out(osc_band_out), .osc_gain_band_out(osc_gain_band_out),
    .pump_current_code_out(pump_current_code_out), .modulator_order_out(modulator_order_out),
    .integer_mode_out(integer_mode_out), .fb_divider_word_out(fb_divider_word_out),
    .fb_divider_reset_out(fb_divider_reset_out), .output_clk_out(output_clk_out),
    .serial_out_unlock_pin_out(serial_out_unlock_pin_out));

  always #12.5 core_clk_in = ~core_clk_in;

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Timeout well above the longest divider measurement
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      close_out();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    if (g !== e)
      n_errors++;
  endtask : chk

  task wr(input logic [3:0] a, input pbd_word_t d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask : wr

  task rd(input logic [3:0] a, input pbd_word_t e, input string nm);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("rvalid", 32'h0000_0001, {31'h0, reg_rvalid_out});
    chk(nm, e, reg_rdata_out);
  endtask : rd

  task step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : step

  // Wait for the first tick of a new period of one output
  task to_rise(input int o);
    step(1);
    while (output_clk_out[o] !== 1'b0) step(1);
    while (output_clk_out[o] !== 1'b1) step(1);
  endtask : to_rise

  // High time and period from a rise; ends on the next rise, so calls chain
  task meas(input int o, output int h, output int p);
    h = 0;
    p = 0;
    while (output_clk_out[o] === 1'b1)
    begin
      h++;
      p++;
      step(1);
    end
    while (output_clk_out[o] !== 1'b1)
    begin
      p++;
      step(1);
    end
  endtask : meas

  initial
  begin
    repeat (12) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    rd(4'h5, 32'h0404_0404, "ratios reset");
    chk("int mode reset", 32'h0000_0003, {30'h0, integer_mode_out});
    $display("test reset done");
    wr(4'h7, 32'h7B15_4000);
    chk("band", 32'h0000_001B, {27'h0, osc_band_out[0]});
    chk("pump code", 32'h0000_0015, {27'h0, pump_current_code_out[0]});
    chk("fb reset", 32'h0000_0001, {31'h0, fb_divider_reset_out[0]});
    chk("int mode", 32'h0000_0000, {31'h0, integer_mode_out[0]});
    for (int k = 0; k < 5; k++)
    begin
      wr(4'h9, {k[2:0], 29'h0E00_4000});
      chk("fb reset 2 set", 32'h0000_0001, {31'h0, fb_divider_reset_out[1]});
      wr(4'h9, {k[2:0], 29'h0E00_0000});
      chk("fb reset 2 clear", 32'h0000_0000, {31'h0, fb_divider_reset_out[1]});
      chk("order", k, {29'h0, modulator_order_out[1]});
      chk("int mode 2", {31'h0, k == 0}, {31'h0, integer_mode_out[1]});
      chk("band 2", 32'h0000_000E, {27'h0, osc_band_out[1]});
    end
    wr(4'hC, 32'h8000_0000);
    wr(4'hE, 32'h8000_0000);
    chk("gain band", 32'h0000_0003, {30'h0, osc_gain_band_out});
    wr(4'hB, 32'h0000_00A5);
    rd(4'hB, 32'h0000_00A5, "calibrated word");
    $display("test settings done");
    @(posedge core_clk_in);
    pll_lock_in <= 2'h1;
    step(3);
    rd(4'hF, 32'h0020_0000, "status pll1");
    @(posedge core_clk_in);
    pll_lock_in <= 2'h2;
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, 32'h0080_0000, "status pll2");
    @(posedge core_clk_in);
    spi_data_in <= 1'b1;
    step(3);
    chk("pin data", 32'h0000_0001, {31'h0, serial_out_unlock_pin_out});
    @(posedge core_clk_in);
    pll_lock_in <= 2'h0;
    wr(4'h6, 32'h0000_0001);
    chk("fb word", 32'h0000_0001, fb_divider_word_out[0]);
    wr(4'h8, 32'h1234_5678);
    chk("fb word 2", 32'h1234_5678, fb_divider_word_out[1]);
    @(posedge core_clk_in);
    spi_data_in <= 1'b0;
    step(4);
    chk("pin unlocked", 32'h0000_0001, {31'h0, serial_out_unlock_pin_out});
    @(posedge core_clk_in);
    pll_lock_in <= 2'h1;
    step(4);
    chk("pin one locked", 32'h0000_0000, {31'h0, serial_out_unlock_pin_out});
    $display("test lock done");
    to_rise(0);
    meas(0, hi, p1);
    chk("period reset", 32'h0000_0004, p1);
    wr(4'h3, 32'h0000_0200);
    wr(4'h5, 32'hFF03_0005);
    for (int o = 0; o < 4; o++)
    begin
      to_rise(o);
      meas(o, hi, p1);
      if (o == 1)
      begin
        meas(o, hi, p2);
        chk("half step pair", 32'h0000_0009, p1 + p2);
      end
      else
      begin
        chk("period", exp_p[o], p1);
        chk("high time", exp_p[o] / 2, hi);
      end
    end
    $display("test dividers done");
    close_out();
  end
endmodule : pbd_ctrl_tb
